// file: hdl/switch_table_defines.svh
// Offsets, field positions and codes of the table access register page
`ifndef SWITCH_TABLE_DEFINES_SVH
`define SWITCH_TABLE_DEFINES_SVH
`define SRCH_CTRL_ADDR 8'h50
`define KEY0_BASE 8'h60
`define DATA0_BASE 8'h68
`define KEY1_BASE 8'h70
`define DATA1_BASE 8'h78
`define VCMD_ADDR 8'h80
`define VIDX_LO_ADDR 8'h81
`define VIDX_HI_ADDR 8'h82
`define KEY_LEN 8'h08
`define DATA_LEN 8'h04
`define DATA_LAST 8'h03
`define START_BIT 7
`define HIT_BIT 0
`define VALID_BIT 16
`define STATIC_BIT 15
`define AGE_BIT 14
`define TC_MSB 13
`define TC_LSB 11
`define MAP_CPU_BIT 8
`define MAP_PORT_MSB 5
`define UNI_PORT_MSB 3
`define VID_LSB 48
`define OP_MSB 1
`define RSV_MSB 6
`define RSV_LSB 2
`define VIDX_HI_MSB 3
`define OP_WRITE 2'h0
`define OP_READ 2'h1
`define OP_CLEAR 2'h2
`define OP_RSV 2'h3
`endif

// file: hdl/switch_table_pkg.sv
// Types shared by the table access register logic
package switch_table_pkg;
  `include "switch_table_defines.svh"

  typedef struct packed {
    logic valid;
    logic is_static;
    logic age;
    logic [2:0] traffic_class;
    logic multicast;
    logic [8:0] port_field;
    logic [11:0] vlan_id;
    logic [47:0] mac;
  } found_entry_s;

  typedef enum logic [1:0] {V_IDLE, V_WAIT, V_FINISH} vlan_state_e;

  // Builds the 32-bit search result data word from a found entry
  function automatic logic [31:0] result_word(input found_entry_s e);
    logic [31:0] w;
    w = 32'h0;
    w[`VALID_BIT] = e.valid;
    w[`STATIC_BIT] = e.is_static;
    w[`AGE_BIT] = e.age;
    w[`TC_MSB:`TC_LSB] = e.traffic_class;
    if (e.multicast) begin
      w[`MAP_CPU_BIT] = e.port_field[`MAP_CPU_BIT];
      w[`MAP_PORT_MSB:0] = e.port_field[`MAP_PORT_MSB:0];
    end else begin
      w[`UNI_PORT_MSB:0] = e.port_field[`UNI_PORT_MSB:0];
    end
    return w;
  endfunction : result_word
endpackage : switch_table_pkg

// file: hdl/vlan_cmd_if.sv
// Command handshake between register page and VLAN command unit
`timescale 1ns/1ps
interface vlan_cmd_if;
  logic start;
  logic [1:0] op;
  logic [11:0] index;
  logic done;
  modport ctrl (output start, output op, output index, input done);
  modport unit (input start, input op, input index, output done);
endinterface : vlan_cmd_if

// file: hdl/vlan_cmd_unit.sv
// Sequencer that runs one VLAN table operation against the table port
`timescale 1ns/1ps
`include "switch_table_defines.svh"
module vlan_cmd_unit
  import switch_table_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  vlan_cmd_if.unit cmd,
  output logic vtbl_req_o,
  output logic [1:0] vtbl_op_o,
  output logic [11:0] vtbl_index_o,
  input wire logic vtbl_ack_i
);
  vlan_state_e state;
  vlan_state_e next_state;
  wire start_rsv = cmd.start && (cmd.op == `OP_RSV);

  always_comb begin
    case (state)
      V_IDLE: begin
        if (start_rsv) next_state = V_FINISH;
        else if (cmd.start) next_state = V_WAIT;
        else next_state = V_IDLE;
      end
      V_WAIT: next_state = vtbl_ack_i ? V_FINISH : V_WAIT;
      V_FINISH: next_state = V_IDLE;
      default: next_state = V_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= V_IDLE;
      vtbl_op_o <= `OP_WRITE;
      vtbl_index_o <= 12'h000;
    end else begin
      state <= next_state;
      if (cmd.start && state == V_IDLE) begin
        vtbl_op_o <= cmd.op;
        vtbl_index_o <= cmd.index;
      end
    end
  end

  assign vtbl_req_o = (state == V_WAIT);
  assign cmd.done = (state == V_FINISH);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_rsv_no_access;
    start_rsv && state == V_IDLE |=> cmd.done && !vtbl_req_o;
  endproperty
  a_rsv_no_access: assert property (p_rsv_no_access) else $error("reserved op touched table");

  property p_ack_done;
    vtbl_req_o && vtbl_ack_i |=> cmd.done ##1 !vtbl_req_o;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("ack did not finish command");
endmodule : vlan_cmd_unit

// file: hdl/switch_table_access_regs.sv
// Register page for address table search results and VLAN table commands
// What this block does
// - Result data bit 16 shows valid flag of the found entry.
// - Result data bit 15 shows static flag of the found entry.
// - Result data bit 14 shows age flag of the found entry.
// - Result data bits 13:11 show the entry traffic class.
// - Reading a result data slot clears that slot.
// - Reading a result data slot lets the scan resume.
// - Multicast entries put the port map in bits 8:0.
// - Port map bit 8 selects the management processor port.
// - Port map bits 5:0 select switch ports 5 to 0.
// - Unicast entries put a port number in the low field instead.
// - Unicast port number in bits 3:0, bits 8:4 reserved.
// - Writing 1 to command bit 7 launches the VLAN operation.
// - Command bit 7 clears when the operation finishes.
// - Operation code 00 write, 01 read, 10 clear table, 11 reserved.
// - Read and write use the 12-bit entry index.
// - Search start bit begins a scan and clears when scan ends.
// - Search hit flag sets on a found entry, clears on result read.
// - Key slot holds VLAN id in 59:48 and MAC in 47:0.
`timescale 1ns/1ps
`include "switch_table_defines.svh"
module switch_table_access_regs
  import switch_table_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic scan_run_o,
  output logic scan_resume_o,
  input wire logic scan_found_i,
  input wire logic scan_slot_i,
  input wire found_entry_s scan_entry_i,
  input wire logic scan_done_i,
  output logic vtbl_req_o,
  output logic [1:0] vtbl_op_o,
  output logic [11:0] vtbl_index_o,
  input wire logic vtbl_ack_i
);
  // Address window test and byte lane pick
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base,
                                     input logic [7:0] len);
    logic [7:0] off;
    off = a - base;
    return off < len;
  endfunction : in_window

  function automatic logic [7:0] lane_of(input logic [63:0] v, input logic [7:0] a,
                                         input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    return v[off[2:0]*8 +: 8];
  endfunction : lane_of

  vlan_cmd_if cmd_bus ();

  found_entry_s slot [2];
  logic search_run;
  logic search_hit;
  logic vcmd_busy;
  logic [4:0] vcmd_rsv;
  logic [1:0] vcmd_op;
  logic [11:0] vidx;

  // Write decode
  wire wr_sctl = reg_wr_i && (reg_addr_i == `SRCH_CTRL_ADDR);
  wire wr_vcmd = reg_wr_i && (reg_addr_i == `VCMD_ADDR) && !vcmd_busy;
  wire wr_vidx_lo = reg_wr_i && (reg_addr_i == `VIDX_LO_ADDR) && !vcmd_busy;
  wire wr_vidx_hi = reg_wr_i && (reg_addr_i == `VIDX_HI_ADDR) && !vcmd_busy;
  wire scan_launch = wr_sctl && reg_wdata_i[`START_BIT];
  wire vlan_launch = wr_vcmd && reg_wdata_i[`START_BIT];

  // A read of the last byte of a result data slot consumes it
  wire [1:0] rd_last;
  assign rd_last[0] = reg_rd_i && (reg_addr_i == `DATA0_BASE + `DATA_LAST);
  assign rd_last[1] = reg_rd_i && (reg_addr_i == `DATA1_BASE + `DATA_LAST);
  wire [1:0] fill;
  assign fill[0] = scan_found_i && !scan_slot_i;
  assign fill[1] = scan_found_i && scan_slot_i;

  // Search control and result slots
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      search_run <= 1'b0;
    end else if (scan_launch) begin
      search_run <= 1'b1;
    end else if (scan_done_i) begin
      search_run <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      search_hit <= 1'b0;
    end else if (scan_found_i) begin
      search_hit <= 1'b1;
    end else if (|rd_last) begin
      search_hit <= 1'b0;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        slot[i] <= '0;
      end else if (fill[i]) begin
        slot[i] <= scan_entry_i;
      end else if (rd_last[i]) begin
        slot[i] <= '0;
      end
    end
  end

  assign scan_run_o = search_run;
  assign scan_resume_o = search_run && (|rd_last);

  // VLAN command and index registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vcmd_busy <= 1'b0;
      vcmd_rsv <= 5'h00;
      vcmd_op <= `OP_WRITE;
    end else begin
      if (wr_vcmd) begin
        vcmd_rsv <= reg_wdata_i[`RSV_MSB:`RSV_LSB];
        vcmd_op <= reg_wdata_i[`OP_MSB:0];
      end
      if (vlan_launch) begin
        vcmd_busy <= 1'b1;
      end else if (cmd_bus.done) begin
        vcmd_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vidx <= 12'h000;
    end else if (wr_vidx_lo) begin
      vidx[7:0] <= reg_wdata_i;
    end else if (wr_vidx_hi) begin
      vidx[11:8] <= reg_wdata_i[`VIDX_HI_MSB:0];
    end
  end

  assign cmd_bus.start = vlan_launch;
  assign cmd_bus.op = reg_wdata_i[`OP_MSB:0];
  assign cmd_bus.index = vidx;

  vlan_cmd_unit u_vlan_cmd (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cmd(cmd_bus.unit),
    .vtbl_req_o(vtbl_req_o),
    .vtbl_op_o(vtbl_op_o),
    .vtbl_index_o(vtbl_index_o),
    .vtbl_ack_i(vtbl_ack_i)
  );

  // Read selection
  wire [31:0] data_word0 = result_word(slot[0]);
  wire [31:0] data_word1 = result_word(slot[1]);
  wire [63:0] key_word0 = {4'h0, slot[0].vlan_id, slot[0].mac};
  wire [63:0] key_word1 = {4'h0, slot[1].vlan_id, slot[1].mac};
  wire [7:0] sctl_byte = {search_run, 6'h00, search_hit};
  wire [7:0] vcmd_byte = {vcmd_busy, vcmd_rsv, vcmd_op};
  wire [7:0] vidx_hi_byte = {4'h0, vidx[11:8]};
  wire [7:0] rd_next =
    (reg_addr_i == `SRCH_CTRL_ADDR) ? sctl_byte :
    in_window(reg_addr_i, `KEY0_BASE, `KEY_LEN) ? lane_of(key_word0, reg_addr_i, `KEY0_BASE) :
    in_window(reg_addr_i, `DATA0_BASE, `DATA_LEN) ?
      lane_of({32'h0, data_word0}, reg_addr_i, `DATA0_BASE) :
    in_window(reg_addr_i, `KEY1_BASE, `KEY_LEN) ? lane_of(key_word1, reg_addr_i, `KEY1_BASE) :
    in_window(reg_addr_i, `DATA1_BASE, `DATA_LEN) ?
      lane_of({32'h0, data_word1}, reg_addr_i, `DATA1_BASE) :
    (reg_addr_i == `VCMD_ADDR) ? vcmd_byte :
    (reg_addr_i == `VIDX_LO_ADDR) ? vidx[7:0] :
    (reg_addr_i == `VIDX_HI_ADDR) ? vidx_hi_byte : 8'h00;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_fill0;
    fill[0] && !reset_i;
  endsequence

  sequence s_vlan_issue;
    vlan_launch && reg_wdata_i[`OP_MSB:0] != `OP_RSV;
  endsequence

  property p_valid_bit;
    s_fill0 |=> data_word0[`VALID_BIT] == $past(scan_entry_i.valid);
  endproperty
  a_valid_bit: assert property (p_valid_bit) else $error("valid bit not reported");

  property p_static_age;
    s_fill0 |=> data_word0[`STATIC_BIT] == $past(scan_entry_i.is_static)
      && data_word0[`AGE_BIT] == $past(scan_entry_i.age);
  endproperty
  a_static_age: assert property (p_static_age) else $error("static or age wrong");

  property p_tc_field;
    s_fill0 |=> data_word0[`TC_MSB:`TC_LSB] == $past(scan_entry_i.traffic_class);
  endproperty
  a_tc_field: assert property (p_tc_field) else $error("traffic class wrong");

  property p_unicast_field;
    s_fill0 ##0 !scan_entry_i.multicast |=>
      data_word0[`MAP_CPU_BIT:0] == {5'h00, $past(scan_entry_i.port_field[`UNI_PORT_MSB:0])};
  endproperty
  a_unicast_field: assert property (p_unicast_field) else $error("unicast port wrong");

  property p_read_clears;
    rd_last[1] && !fill[1] |=> data_word1 == 32'h0 && key_word1 == 64'h0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("slot not cleared");

  property p_resume;
    search_run && (rd_last[0] || rd_last[1]) |-> scan_resume_o;
  endproperty
  a_resume: assert property (p_resume) else $error("scan not resumed");

  property p_hit_flag;
    scan_found_i |=> search_hit;
  endproperty
  a_hit_flag: assert property (p_hit_flag) else $error("hit flag not set");

  property p_scan_done;
    scan_done_i && !scan_launch |=> !scan_run_o;
  endproperty
  a_scan_done: assert property (p_scan_done) else $error("start bit not cleared");

  property p_vlan_issue;
    s_vlan_issue |=> vtbl_req_o && vcmd_busy && vtbl_index_o == $past(vidx);
  endproperty
  a_vlan_issue: assert property (p_vlan_issue) else $error("vlan command not issued");

  property p_vlan_done;
    vtbl_req_o && vtbl_ack_i |=> ##1 !vcmd_busy;
  endproperty
  a_vlan_done: assert property (p_vlan_done) else $error("busy bit stuck");

  property p_index_high;
    reg_rd_i && reg_addr_i == `VIDX_HI_ADDR |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_index_high: assert property (p_index_high) else $error("index high bits nonzero");

  sequence s_fill1;
    fill[1] && !reset_i;
  endsequence

  sequence s_slot0_read;
    rd_last[0] && !fill[0];
  endsequence

  property p_valid_bit1;
    s_fill1 |=> data_word1[`VALID_BIT] == $past(scan_entry_i.valid);
  endproperty
  a_valid_bit1: assert property (p_valid_bit1) else $error("slot 1 valid bit wrong");

  property p_static_age1;
    s_fill1 |=> data_word1[`STATIC_BIT] == $past(scan_entry_i.is_static)
      && data_word1[`AGE_BIT] == $past(scan_entry_i.age);
  endproperty
  a_static_age1: assert property (p_static_age1) else $error("slot 1 static or age wrong");

  property p_tc_field1;
    s_fill1 |=> data_word1[`TC_MSB:`TC_LSB] == $past(scan_entry_i.traffic_class);
  endproperty
  a_tc_field1: assert property (p_tc_field1) else $error("slot 1 traffic class wrong");

  property p_group_cpu;
    s_fill0 ##0 scan_entry_i.multicast |=>
      data_word0[`MAP_CPU_BIT] == $past(scan_entry_i.port_field[`MAP_CPU_BIT]);
  endproperty
  a_group_cpu: assert property (p_group_cpu) else $error("group map cpu bit wrong");

  property p_group_ports;
    s_fill0 ##0 scan_entry_i.multicast |=>
      data_word0[`MAP_PORT_MSB:0] == $past(scan_entry_i.port_field[`MAP_PORT_MSB:0])
      && data_word0[`MAP_CPU_BIT-1:`MAP_PORT_MSB+1] == 2'h0;
  endproperty
  a_group_ports: assert property (p_group_ports) else $error("group map ports wrong");

  property p_unicast_field1;
    s_fill1 ##0 !scan_entry_i.multicast |=>
      data_word1[`MAP_CPU_BIT:0] == {5'h00, $past(scan_entry_i.port_field[`UNI_PORT_MSB:0])};
  endproperty
  a_unicast_field1: assert property (p_unicast_field1) else $error("slot 1 port wrong");

  property p_key_slot0;
    s_fill0 |=> key_word0 == {4'h0, $past(scan_entry_i.vlan_id), $past(scan_entry_i.mac)};
  endproperty
  a_key_slot0: assert property (p_key_slot0) else $error("key slot wrong");

  property p_read_clears0;
    s_slot0_read |=> data_word0 == 32'h0 && key_word0 == 64'h0;
  endproperty
  a_read_clears0: assert property (p_read_clears0) else $error("slot 0 not cleared");

  property p_hit_clear;
    s_slot0_read ##0 !scan_found_i |=> !search_hit;
  endproperty
  a_hit_clear: assert property (p_hit_clear) else $error("hit flag not cleared");

  property p_scan_start;
    scan_launch |=> scan_run_o;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan not started");

  property p_no_resume_idle;
    !search_run |-> !scan_resume_o;
  endproperty
  a_no_resume_idle: assert property (p_no_resume_idle) else $error("resume while idle");

  property p_vlan_op;
    s_vlan_issue |=> vtbl_op_o == $past(reg_wdata_i[`OP_MSB:0]);
  endproperty
  a_vlan_op: assert property (p_vlan_op) else $error("vlan op code wrong");

  property p_cmd_refused;
    reg_wr_i && reg_addr_i == `VCMD_ADDR && vcmd_busy |=> $stable(vcmd_op) && $stable(vcmd_rsv);
  endproperty
  a_cmd_refused: assert property (p_cmd_refused) else $error("command changed while busy");

  property p_index_refused;
    reg_wr_i && (reg_addr_i == `VIDX_LO_ADDR || reg_addr_i == `VIDX_HI_ADDR) && vcmd_busy
      |=> $stable(vidx);
  endproperty
  a_index_refused: assert property (p_index_refused) else $error("index changed while busy");

  property p_busy_readback;
    reg_rd_i && reg_addr_i == `VCMD_ADDR |=> reg_rdata_o[`START_BIT] == $past(vcmd_busy);
  endproperty
  a_busy_readback: assert property (p_busy_readback) else $error("start bit readback wrong");
endmodule : switch_table_access_regs

// file: bench/tb_switch_table_access_regs.sv
// Self-checking testbench for the table access register page
`timescale 1ns/1ps
module tb_switch_table_access_regs;
  import switch_table_pkg::*;
  logic clk_i = 0;
  logic reset_i = 1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 0;
  logic [7:0] reg_rdata_o;
  logic scan_run_o, scan_resume_o, scan_found_i = 0, scan_slot_i = 0, scan_done_i = 0;
  found_entry_s scan_entry_i = '0;
  logic vtbl_req_o, vtbl_ack_i = 0;
  logic [1:0] vtbl_op_o;
  logic [11:0] vtbl_index_o;
  int bad_count = 0;
  int checks = 0;
  logic resume_seen;
  found_entry_s e0, e1;

  always #5 clk_i = ~clk_i;

  switch_table_access_regs uut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .scan_run_o(scan_run_o), .scan_resume_o(scan_resume_o),
    .scan_found_i(scan_found_i), .scan_slot_i(scan_slot_i), .scan_entry_i(scan_entry_i),
    .scan_done_i(scan_done_i), .vtbl_req_o(vtbl_req_o), .vtbl_op_o(vtbl_op_o),
    .vtbl_index_o(vtbl_index_o), .vtbl_ack_i(vtbl_ack_i));

  task automatic finish_test();
    $display("Counts: checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    #1 resume_seen = scan_resume_o;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask : rd

  task automatic rdn(input logic [7:0] a, input int n, output logic [63:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < n; i++) begin
      rd(a + 8'(i), b);
      v[8*i +: 8] = b;
    end
  endtask : rdn

  // Data word as the result slot must present it
  function automatic logic [31:0] exp_word(input found_entry_s e);
    logic [8:0] low;
    low = e.multicast ? {e.port_field[8], 2'b00, e.port_field[5:0]}
                      : {5'h00, e.port_field[3:0]};
    return {15'h0000, e.valid, e.is_static, e.age, e.traffic_class, 2'b00, low};
  endfunction : exp_word

  task automatic found(input logic s, input found_entry_s e);
    @(posedge clk_i);
    scan_found_i <= 1;
    scan_slot_i <= s;
    scan_entry_i <= e;
    @(posedge clk_i);
    scan_found_i <= 0;
    @(posedge clk_i);
  endtask : found

  task automatic test_reset();
    logic [63:0] v;
    rdn(8'h80, 3, v);
    chk(v, 64'h0, "command and index after reset");
    rdn(8'h50, 1, v);
    chk(v, 64'h0, "search control after reset");
    rdn(8'h90, 1, v);
    chk(v, 64'h0, "unmapped read");
    chk({scan_run_o, vtbl_req_o}, 2'b00, "outputs after reset");
  endtask : test_reset

  task automatic test_slot(input logic s, input found_entry_s e);
    logic [63:0] v;
    logic [7:0] b;
    found(s, e);
    rd(8'h50, b);
    chk(b, 8'h81, "hit flag set while running");
    rdn(s ? 8'h70 : 8'h60, 8, v);
    chk(v, {4'h0, e.vlan_id, e.mac}, "key slot");
    rdn(s ? 8'h78 : 8'h68, 4, v);
    chk(v, 64'(exp_word(e)), "result word");
    chk(resume_seen, 1'b1, "resume on last byte");
    rd(8'h50, b);
    chk(b, 8'h80, "hit flag cleared by read");
    rdn(s ? 8'h78 : 8'h68, 4, v);
    chk(v, 64'h0, "slot cleared by read");
  endtask : test_slot

  task automatic test_scan();
    logic [7:0] b;
    wr(8'h50, 8'h80);
    #1 chk(scan_run_o, 1'b1, "scan running");
    test_slot(1'b0, e0);
    test_slot(1'b1, e1);
    @(posedge clk_i);
    scan_done_i <= 1;
    @(posedge clk_i);
    scan_done_i <= 0;
    #1 chk(scan_run_o, 1'b0, "scan done clears start");
    rd(8'h50, b);
    chk(b, 8'h00, "control idle after scan");
  endtask : test_scan

  task automatic run_cmd(input logic [7:0] cmd, input logic req_exp);
    logic [7:0] b;
    int n;
    wr(8'h80, cmd);
    #1 chk(vtbl_req_o, req_exp, "table request");
    if (req_exp) begin
      chk({vtbl_op_o, vtbl_index_o}, {cmd[1:0], 12'ha34}, "op and index");
      rd(8'h80, b);
      chk(b[7], 1'b1, "busy while running");
      wr(8'h81, 8'h00);
      @(posedge clk_i);
      vtbl_ack_i <= 1;
      @(posedge clk_i);
      vtbl_ack_i <= 0;
    end
    n = 0;
    do begin
      rd(8'h80, b);
      n++;
    end while (b[7] !== 1'b0 && n < 10);
    chk(b, {1'b0, cmd[6:0]}, "command done readback");
    chk(vtbl_req_o, 1'b0, "request released");
    rd(8'h81, b);
    chk(b, 8'h34, "index kept while busy");
    if (n >= 10) begin
      bad_count++;
      finish_test();
    end
  endtask : run_cmd

  task automatic test_vlan();
    logic [63:0] v;
    wr(8'h81, 8'h34);
    wr(8'h82, 8'hfa);
    rdn(8'h81, 2, v);
    chk(v, 64'h0a34, "index readback");
    run_cmd(8'h80, 1'b1);
    run_cmd(8'h81, 1'b1);
    run_cmd(8'h82, 1'b1);
    run_cmd(8'hfb, 1'b0);
  endtask : test_vlan

  initial begin
    e0 = '{1'b1, 1'b0, 1'b1, 3'h5, 1'b1, 9'h1e5, 12'habc, 48'h0123456789ab};
    e1 = '{1'b1, 1'b1, 1'b0, 3'h2, 1'b0, 9'h1f5, 12'h5a1, 48'hfedcba987654};
    repeat (16) @(posedge clk_i);
    reset_i <= 0;
    test_reset();
    test_scan();
    test_vlan();
    finish_test();
  end
endmodule : tb_switch_table_access_regs
